// file: tpa_pkg.sv
// Purpose: Constants, register map and helpers for the timer prescaler block
// Assumes: 8-bit register port, 20 MHz system clock
// Notes: Register offsets are word indices on the plain register port
package tpa_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int TPA_DW = 8;
   localparam int TPA_AW = 3;
   localparam int TPA_PS_W = 8;
   localparam int TPA_CNT_W = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [TPA_AW-1:0] TPA_OFF_CTRL = 3'h0;
   localparam logic [TPA_AW-1:0] TPA_OFF_CNT_LO = 3'h1;
   localparam logic [TPA_AW-1:0] TPA_OFF_CNT_HI = 3'h2;
   localparam logic [TPA_AW-1:0] TPA_OFF_INTC = 3'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions of timer_control_reg
   localparam int TPA_CTRL_ON_BIT = 7;
   localparam int TPA_CTRL_MODE8_BIT = 6;
   localparam int TPA_CTRL_BYP_BIT = 3;
   localparam int TPA_CTRL_RATIO_MSB = 2;
   localparam int TPA_CTRL_RATIO_LSB = 0;

   // Field positions of interrupt_control_reg
   localparam int TPA_INTC_IE_BIT = 5;
   localparam int TPA_INTC_IF_BIT = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and limits
   localparam logic [TPA_DW-1:0] TPA_CTRL_RST = 8'h00;
   localparam logic [TPA_DW-1:0] TPA_ZERO_BYTE = 8'h00;
   localparam logic [TPA_PS_W-1:0] TPA_PS_RST = 8'h00;
   localparam logic [TPA_CNT_W-1:0] TPA_CNT_RST = 16'h0000;
   localparam logic [7:0] TPA_CNT8_MAX = 8'hff;
   localparam logic [TPA_CNT_W-1:0] TPA_CNT16_MAX = 16'hffff;
   localparam logic [TPA_PS_W-1:0] TPA_PS_ONE = 8'h01;
   localparam logic [7:0] TPA_CNT8_ONE = 8'h01;
   localparam logic [TPA_CNT_W-1:0] TPA_CNT16_ONE = 16'h0001;

   ////////////////////////////////////////////////////////////////////////////
   // Ratio code to terminal mask: code n divides by 2^(n+1)
   function automatic logic [TPA_PS_W-1:0] tpa_ratio_mask(input logic [2:0] r);
      logic [8:0] m;
      m = (9'h002 << r) - 9'h001;
      return m[TPA_PS_W-1:0];
   endfunction

endpackage

// file: tpa_pre_if.sv
// Purpose: Carries count source and settings to the prescaler, step back
// Assumes: Single clock domain
// Notes: ctl is the timer side, pre is the prescaler side
`timescale 1ns/10ps
interface tpa_pre_if;
   logic tick;
   logic clear;
   logic bypass;
   logic [2:0] ratio;
   logic inc;

   modport ctl (output tick, output clear, output bypass, output ratio, input inc);
   modport pre (input tick, input clear, input bypass, input ratio, output inc);
endinterface

// file: tpa_prescaler.sv
// Purpose: 8-bit prescale counter dividing the timer count source
// Assumes: Tick is a one-cycle pulse synchronous to i_sys_clk
// Notes: Step output is combinational; the timer registers it
`timescale 1ns/10ps
module tpa_prescaler (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   tpa_pre_if.pre pif
);
   import tpa_pkg::*;

   logic [TPA_PS_W-1:0] ps_q;
   logic [TPA_PS_W-1:0] term_mask;
   logic at_term;

   ////////////////////////////////////////////////////////////////////////////
   // Terminal count for the selected ratio
   assign term_mask = tpa_ratio_mask(pif.ratio);
   assign at_term = (ps_q & term_mask) == term_mask;

   // Prescale counter; no software view of it exists
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ps_q <= TPA_PS_RST;
      end else if (pif.clear) begin
         ps_q <= TPA_PS_RST;
      end else if (pif.tick && !pif.bypass) begin
         ps_q <= ps_q + TPA_PS_ONE;
      end
   end

   // Step the timer: raw source when bypassed, else once per period
   // A clear swallows the step so the new period starts clean
   assign pif.inc = pif.bypass ? pif.tick : (pif.tick && at_term && !pif.clear);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   AST_PS_CLEAR: assert property (pif.clear |=> ps_q == TPA_PS_RST)
      else $error("prescale count not cleared");
   AST_PS_BYPASS: assert property (pif.bypass |-> pif.inc == pif.tick)
      else $error("bypass does not pass the source");
   AST_PS_DIV: assert property (pif.inc && !pif.bypass |-> ((ps_q & term_mask) == term_mask))
      else $error("step outside terminal count");
   AST_PS_DIV2: assert property (!pif.bypass && pif.ratio == 3'h0 && pif.tick && !pif.clear
      ##1 !pif.bypass && pif.ratio == 3'h0 && pif.tick && !pif.clear |-> pif.inc || $past(pif.inc))
      else $error("divide by two missed a step");

   COV_PS_256: cover property (!pif.bypass && pif.ratio == 3'h7 && pif.inc);
endmodule

// file: tpa_timer.sv
// Purpose: Timer with assignable prescaler, register port and overflow irq
// Assumes: Strobes one cycle, never together; read data one cycle later
// Notes: Offsets 0..3; unmapped reads return zero, unmapped writes ignored
`timescale 1ns/10ps
module tpa_timer (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_count_tick,
   input wire logic [tpa_pkg::TPA_AW-1:0] i_addr,
   input wire logic [tpa_pkg::TPA_DW-1:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   output logic [tpa_pkg::TPA_DW-1:0] o_rd_data,
   output logic o_irq,
   output logic o_overflow
);
   import tpa_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic on_q;
   logic mode8_q;
   logic byp_q;
   logic [2:0] ratio_q;
   logic [TPA_CNT_W-1:0] cnt_q;
   logic ie_q;
   logic flag_q;
   logic [TPA_DW-1:0] rd_data_q;
   logic irq_q;
   logic ovf_q;
   logic wr_ctrl;
   logic wr_lo;
   logic wr_hi;
   logic wr_intc;
   logic rd_intc;
   logic wr_cnt;
   logic wrap;
   logic [TPA_DW-1:0] ctrl_byte;
   logic [TPA_DW-1:0] intc_byte;
   logic [TPA_DW-1:0] rd_mux;

   tpa_pre_if pif ();

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   assign wr_ctrl = i_wr_en && (i_addr == TPA_OFF_CTRL);
   assign wr_lo = i_wr_en && (i_addr == TPA_OFF_CNT_LO);
   assign wr_hi = i_wr_en && (i_addr == TPA_OFF_CNT_HI);
   assign wr_intc = i_wr_en && (i_addr == TPA_OFF_INTC);
   assign rd_intc = i_rd_en && (i_addr == TPA_OFF_INTC);
   assign wr_cnt = wr_lo || wr_hi;

   ////////////////////////////////////////////////////////////////////////////
   // Control register; writes are taken while running
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         on_q <= TPA_CTRL_RST[TPA_CTRL_ON_BIT];
         mode8_q <= TPA_CTRL_RST[TPA_CTRL_MODE8_BIT];
         byp_q <= TPA_CTRL_RST[TPA_CTRL_BYP_BIT];
         ratio_q <= TPA_CTRL_RST[TPA_CTRL_RATIO_MSB:TPA_CTRL_RATIO_LSB];
      end else if (wr_ctrl) begin
         on_q <= i_wr_data[TPA_CTRL_ON_BIT];
         mode8_q <= i_wr_data[TPA_CTRL_MODE8_BIT];
         byp_q <= i_wr_data[TPA_CTRL_BYP_BIT];
         ratio_q <= i_wr_data[TPA_CTRL_RATIO_MSB:TPA_CTRL_RATIO_LSB];
      end
   end

   // Control byte as software sees it; unused bits read zero
   always_comb begin
      ctrl_byte = TPA_ZERO_BYTE;
      ctrl_byte[TPA_CTRL_ON_BIT] = on_q;
      ctrl_byte[TPA_CTRL_MODE8_BIT] = mode8_q;
      ctrl_byte[TPA_CTRL_BYP_BIT] = byp_q;
      ctrl_byte[TPA_CTRL_RATIO_MSB:TPA_CTRL_RATIO_LSB] = ratio_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler hookup
   // A stopped timer feeds no ticks, so the prescaler holds as well
   assign pif.tick = i_count_tick && on_q;
   assign pif.clear = wr_cnt && !byp_q;
   assign pif.bypass = byp_q;
   assign pif.ratio = ratio_q;

   tpa_prescaler u_pre (
      .i_sys_clk (i_sys_clk),
      .i_rst (i_rst),
      .pif (pif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Wrap from all ones, width set by the mode bit
   // A count write in the same cycle beats the step, so no false wrap
   assign wrap = pif.inc && !wr_cnt && (mode8_q ? (cnt_q[7:0] == TPA_CNT8_MAX) : (cnt_q == TPA_CNT16_MAX));

   // Timer count; software writes beat a step in the same cycle
   // In 8-bit mode only the low byte counts, high byte stays put
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= TPA_CNT_RST;
      end else if (wr_lo) begin
         cnt_q[7:0] <= i_wr_data;
      end else if (wr_hi) begin
         cnt_q[15:8] <= i_wr_data;
      end else if (pif.inc) begin
         if (mode8_q) begin
            cnt_q[7:0] <= cnt_q[7:0] + TPA_CNT8_ONE;
         end else begin
            cnt_q <= cnt_q + TPA_CNT16_ONE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt enable
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ie_q <= 1'b0;
      end else if (wr_intc) begin
         ie_q <= i_wr_data[TPA_INTC_IE_BIT];
      end
   end

   // Sticky overflow flag; a wrap beats a clearing read or write
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         flag_q <= 1'b0;
      end else if (wrap) begin
         flag_q <= 1'b1;
      end else if (rd_intc) begin
         flag_q <= 1'b0;
      end else if (wr_intc) begin
         flag_q <= i_wr_data[TPA_INTC_IF_BIT];
      end
   end

   always_comb begin
      intc_byte = TPA_ZERO_BYTE;
      intc_byte[TPA_INTC_IE_BIT] = ie_q;
      intc_byte[TPA_INTC_IF_BIT] = flag_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; the prescale count has no address
   always_comb begin
      unique case (i_addr)
         TPA_OFF_CTRL: rd_mux = ctrl_byte;
         TPA_OFF_CNT_LO: rd_mux = cnt_q[7:0];
         TPA_OFF_CNT_HI: rd_mux = cnt_q[15:8];
         TPA_OFF_INTC: rd_mux = intc_byte;
         default: rd_mux = TPA_ZERO_BYTE;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_data_q <= TPA_ZERO_BYTE;
      end else if (i_rd_en) begin
         rd_data_q <= rd_mux;
      end else begin
         rd_data_q <= TPA_ZERO_BYTE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; irq trails the flag by one cycle to stay registered
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= flag_q && ie_q;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= wrap;
      end
   end

   assign o_rd_data = rd_data_q;
   assign o_irq = irq_q;
   assign o_overflow = ovf_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   AST_WRAP_FLAG: assert property (wrap |=> flag_q && o_overflow)
      else $error("wrap did not set the flag");
   AST_WRAP8: assert property (pif.inc && mode8_q && cnt_q[7:0] == TPA_CNT8_MAX && !wr_cnt
      |=> cnt_q[7:0] == TPA_ZERO_BYTE && flag_q)
      else $error("8-bit wrap wrong");
   AST_IRQ_GATE: assert property (o_irq == $past(flag_q && ie_q))
      else $error("irq does not follow flag and enable");
   AST_IRQ_OFF: assert property (!ie_q ##1 !ie_q |-> !o_irq)
      else $error("irq while disabled");
   AST_CLR_PS: assert property (wr_cnt && !byp_q |-> pif.clear)
      else $error("count write left prescaler running");
   AST_CTRL_KEEP: assert property (wr_cnt |=> $stable(ctrl_byte))
      else $error("count write changed control");
   AST_RD_CLR: assert property (rd_intc && !wrap |=> !flag_q ##0 o_rd_data == $past(intc_byte))
      else $error("read did not return and clear flag");
   AST_HOLD: assert property (!pif.inc && !wr_cnt |=> $stable(cnt_q))
      else $error("count moved without a step");
   AST_BYP_LIVE: assert property (wr_ctrl |=> byp_q == $past(i_wr_data[TPA_CTRL_BYP_BIT]))
      else $error("assignment write not taken");

   COV_WRAP16: cover property (wrap && !mode8_q);
   COV_IRQ: cover property (!o_irq ##1 o_irq);
   COV_CLR_RUN: cover property (pif.clear && on_q);
   COV_SWITCH: cover property (wr_ctrl && on_q && (i_wr_data[TPA_CTRL_BYP_BIT] != byp_q));
endmodule

// file: tpa_testbench.sv
// Purpose: Self-checking bench for the timer prescaler block
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes: Each scenario is a task that drives the block and judges it
`timescale 1ns/10ps
module testbench;
   import tpa_pkg::*;
   localparam logic [7:0] c_on = 8'h80;
   localparam logic [7:0] c_mode8 = 8'h40;
   localparam logic [7:0] c_byp = 8'h08;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_count_tick = 1'b0;
   logic [TPA_AW-1:0] i_addr = 3'h0;
   logic [TPA_DW-1:0] i_wr_data = 8'h00;
   logic i_wr_en = 1'b0;
   logic i_rd_en = 1'b0;
   logic [TPA_DW-1:0] o_rd_data;
   logic o_irq;
   logic o_overflow;
   int err_count = 0;
   int checks = 0;
   int ovf_seen = 0;

   tpa_timer uut (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_count_tick(i_count_tick),
      .i_addr(i_addr),
      .i_wr_data(i_wr_data),
      .i_wr_en(i_wr_en),
      .i_rd_en(i_rd_en),
      .o_rd_data(o_rd_data),
      .o_irq(o_irq),
      .o_overflow(o_overflow)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock and overflow pulse counter
   always #25 i_sys_clk = ~i_sys_clk;

   always @(posedge i_sys_clk) begin
      if (o_overflow === 1'b1) begin
         ovf_seen++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare and bus tasks
   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk1(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask

   // Strobe drops on the next edge, so back-to-back calls leave a gap
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_wr_en <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_sys_clk);
      i_wr_en <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string name);
      @(posedge i_sys_clk);
      i_rd_en <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd_en <= 1'b0;
      @(negedge i_sys_clk);
      chk8(name, exp, o_rd_data);
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge i_sys_clk);
         i_count_tick <= 1'b1;
         @(posedge i_sys_clk);
         i_count_tick <= 1'b0;
      end
      repeat (3) @(posedge i_sys_clk);
   endtask

   task automatic conclude();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      rd_chk(TPA_OFF_CTRL, 8'h00, "ctrl reset");
      rd_chk(TPA_OFF_INTC, 8'h00, "intc reset");
      rd_chk(TPA_OFF_CNT_LO, 8'h00, "count reset");
      chk1("irq reset", 1'b0, o_irq);
   endtask

   // Every ratio: no step one tick short of the period, one step at it
   task automatic t_ratio();
      for (int r = 0; r < 8; r++) begin
         wr(TPA_OFF_CTRL, c_on | 8'(r));
         wr(TPA_OFF_CNT_HI, 8'h00);
         wr(TPA_OFF_CNT_LO, 8'h00);
         ticks((2 << r) - 1);
         rd_chk(TPA_OFF_CNT_LO, 8'h00, "count short of period");
         ticks(1);
         rd_chk(TPA_OFF_CNT_LO, 8'h01, "count at period");
      end
   endtask

   // Mid-period count write restarts the prescale period
   task automatic t_clear();
      wr(TPA_OFF_CTRL, c_on | 8'h02);
      wr(TPA_OFF_CNT_LO, 8'h00);
      ticks(5);
      wr(TPA_OFF_CNT_LO, 8'h10);
      ticks(7);
      rd_chk(TPA_OFF_CNT_LO, 8'h10, "count after clear");
      ticks(1);
      rd_chk(TPA_OFF_CNT_LO, 8'h11, "count full period");
      rd_chk(TPA_OFF_CTRL, c_on | 8'h02, "ctrl kept");
   endtask

   // Assignment switched while the timer keeps running
   task automatic t_bypass();
      wr(TPA_OFF_CTRL, c_on | c_byp | 8'h02);
      wr(TPA_OFF_CNT_LO, 8'h20);
      ticks(3);
      rd_chk(TPA_OFF_CNT_LO, 8'h23, "bypass count");
      rd_chk(TPA_OFF_CTRL, c_on | c_byp | 8'h02, "ctrl bypass");
      wr(TPA_OFF_CTRL, c_on | 8'h02);
      wr(TPA_OFF_CNT_LO, 8'h00);
      ticks(7);
      rd_chk(TPA_OFF_CNT_LO, 8'h00, "reassigned short");
      ticks(1);
      rd_chk(TPA_OFF_CNT_LO, 8'h01, "reassigned period");
   endtask

   // Back-to-back ticks at 1:2, then a high-byte write mid-period
   task automatic t_burst();
      wr(TPA_OFF_CTRL, c_on);
      wr(TPA_OFF_CNT_LO, 8'h00);
      @(posedge i_sys_clk);
      i_count_tick <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      i_count_tick <= 1'b0;
      rd_chk(TPA_OFF_CNT_LO, 8'h04, "burst count");
      ticks(1);
      wr(TPA_OFF_CNT_HI, 8'h00);
      ticks(1);
      rd_chk(TPA_OFF_CNT_LO, 8'h04, "high write clears");
      ticks(1);
      rd_chk(TPA_OFF_CNT_LO, 8'h05, "period after clear");
   endtask

   // 8-bit wrap: flag set, high byte kept, interrupt masked
   task automatic t_ovf8();
      wr(TPA_OFF_CTRL, c_on | c_mode8 | c_byp);
      wr(TPA_OFF_CNT_HI, 8'h12);
      wr(TPA_OFF_CNT_LO, 8'hff);
      ovf_seen = 0;
      ticks(1);
      chk8("overflow pulses", 8'h01, 8'(ovf_seen));
      rd_chk(TPA_OFF_CNT_LO, 8'h00, "low after wrap");
      rd_chk(TPA_OFF_CNT_HI, 8'h12, "high kept");
      chk1("irq masked", 1'b0, o_irq);
      rd_chk(TPA_OFF_INTC, 8'h04, "flag set");
      rd_chk(TPA_OFF_INTC, 8'h00, "flag read clear");
   endtask

   // 16-bit wrap with enable, then masking by the enable bit
   task automatic t_ovf16();
      wr(TPA_OFF_CTRL, c_on | c_byp);
      wr(TPA_OFF_INTC, 8'h20);
      wr(TPA_OFF_CNT_HI, 8'hff);
      wr(TPA_OFF_CNT_LO, 8'hff);
      ticks(1);
      chk1("irq on wrap", 1'b1, o_irq);
      rd_chk(TPA_OFF_CNT_HI, 8'h00, "high after wrap");
      rd_chk(TPA_OFF_INTC, 8'h24, "flag and enable");
      repeat (2) @(posedge i_sys_clk);
      chk1("irq after clear", 1'b0, o_irq);
      wr(TPA_OFF_INTC, 8'h04);
      repeat (2) @(posedge i_sys_clk);
      chk1("irq flag only", 1'b0, o_irq);
      wr(TPA_OFF_INTC, 8'h24);
      repeat (2) @(posedge i_sys_clk);
      chk1("irq unmasked", 1'b1, o_irq);
      wr(TPA_OFF_INTC, 8'h00);
      repeat (2) @(posedge i_sys_clk);
      chk1("irq cleared", 1'b0, o_irq);
   endtask

   // Unmapped places expose nothing and change nothing
   task automatic t_unmapped();
      wr(3'h6, 8'hff);
      rd_chk(3'h5, 8'h00, "unmapped read");
      rd_chk(TPA_OFF_CTRL, c_on | c_byp, "ctrl after stray write");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      t_reset();
      t_ratio();
      t_clear();
      t_bypass();
      t_burst();
      t_ovf8();
      t_ovf16();
      t_unmapped();
      conclude();
   end

   // About 1400 cycles expected; allow a wide margin
   initial begin
      #1000000;
      err_count++;
      conclude();
   end
endmodule
